// ===== core/vpic_pkg.sv
// vpic_pkg: instruction codes, widths and reset values of the controller
// assumes: nothing; every user writes vpic_pkg::name
package vpic_pkg;
  localparam int unsigned NUM_IRQ = 8;
  localparam int unsigned VEC_W = 3;
  localparam int unsigned CODE_W = 4;
  localparam logic [3:0] OP_LOAD_MASK = 4'hE;
  localparam logic [3:0] OP_READ_MASK = 4'h7;
  localparam logic [3:0] OP_CLEAR_MASK = 4'hC;
  localparam logic [3:0] OP_SET_MASK_ALL = 4'h8;
  localparam logic [3:0] OP_BIT_MASK_CLEAR = 4'hA;
  localparam logic [3:0] OP_BIT_MASK_SET = 4'hB;
  localparam logic [3:0] OP_LOAD_STATUS = 4'h9;
  localparam logic [3:0] OP_READ_STATUS = 4'h6;
  localparam logic [3:0] OP_REQ_ENABLE = 4'hF;
  localparam logic [3:0] OP_REQ_DISABLE = 4'hD;
  localparam logic [3:0] OP_READ_VECTOR = 4'h5;
  localparam logic [3:0] OP_CLEAR_ALL_PEND = 4'h1;
  localparam logic [3:0] OP_CLEAR_PEND_MASK = 4'h3;
  localparam logic [3:0] OP_CLEAR_PEND_BUS = 4'h2;
  localparam logic [3:0] OP_CLEAR_LAST_VEC = 4'h4;
  localparam logic [3:0] OP_MASTER_CLEAR = 4'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] PEND_RESET = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] VEC_TOP = 3'h7;
  localparam logic REQ_EN_RESET = 1'b1;
endpackage : vpic_pkg

// ===== core/vpic_prio_if.sv
// vpic_prio_if: carries pending, mask and status into the encoder
// assumes: same clock domain on both sides, no timing inside
`timescale 1ns/100ps
interface vpic_prio_if;
  logic [7:0] pending;
  logic [7:0] mask;
  logic [2:0] status;
  logic [2:0] vector;
  logic hit;
  logic at_level;
  modport ctrl (output pending, output mask, output status,
    input vector, input hit, input at_level);
  modport enc (input pending, input mask, input status,
    output vector, output hit, output at_level);
endinterface : vpic_prio_if

// ===== core/vpic_prio_enc.sv
// vpic_prio_enc: highest unmasked pending index and level compare
// assumes: driven by vpic_ctrl over vpic_prio_if, purely combinational
`timescale 1ns/100ps
module vpic_prio_enc (
  vpic_prio_if.enc p
);
  logic [7:0] live;
  logic [2:0] idx;
  logic found;

  // ----------------------------------------------------------------
  // priority search, bit 7 highest
  // ----------------------------------------------------------------
  always_comb begin
    live = p.pending & ~p.mask;
    idx = 3'h0;
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (live[i]) begin
        idx = 3'(i);
        found = 1'b1;
      end
    end
  end

  assign p.vector = idx;
  assign p.hit = found;
  assign p.at_level = found && (idx >= p.status);
endmodule : vpic_prio_enc

// ===== core/vpic_ctrl.sv
// vpic_ctrl: eight-input vectored priority interrupt controller top
// assumes: single clock, host drives code and buses synchronously,
// interrupt inputs and the latch bypass come from pins
`timescale 1ns/100ps
module vpic_ctrl (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_instruction_enable_n,
  input wire logic [3:0] i_instruction_code,
  input wire logic [7:0] i_interrupt_inputs_n,
  input wire logic i_latch_bypass,
  input wire logic [7:0] i_mask_bus,
  output logic [7:0] o_mask_bus,
  output logic o_mask_bus_oe,
  input wire logic [2:0] i_status_bus,
  output logic [2:0] o_status_bus,
  output logic o_status_bus_oe,
  input wire logic i_group_enable_in,
  output logic o_lowest_group_enabled,
  output logic [2:0] o_vector_out,
  output logic o_vector_oe,
  output logic o_interrupt_request_out,
  output logic o_status_overflow
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ie_n_s1, ie_n;
  logic [3:0] code_s1, code;
  logic [7:0] irq_s1, irq_n;
  logic byp_s1, byp;
  logic [7:0] mbus_s1, mbus;
  logic [2:0] sbus_s1, sbus;
  logic ge_s1, ge;

  // instruction strobe and code
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ie_n_s1 <= 1'b1;
      ie_n <= 1'b1;
      code_s1 <= 4'h0;
      code <= 4'h0;
    end else begin
      ie_n_s1 <= i_instruction_enable_n;
      ie_n <= ie_n_s1;
      code_s1 <= i_instruction_code;
      code <= code_s1;
    end
  end

  // host data buses and group enable
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mbus_s1 <= 8'h00;
      mbus <= 8'h00;
      sbus_s1 <= 3'h0;
      sbus <= 3'h0;
      ge_s1 <= 1'b0;
      ge <= 1'b0;
    end else begin
      mbus_s1 <= i_mask_bus;
      mbus <= mbus_s1;
      sbus_s1 <= i_status_bus;
      sbus <= sbus_s1;
      ge_s1 <= i_group_enable_in;
      ge <= ge_s1;
    end
  end

  // interrupt sources and latch bypass
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_s1 <= 8'hFF;
      irq_n <= 8'hFF;
      byp_s1 <= 1'b0;
      byp <= 1'b0;
    end else begin
      irq_s1 <= i_interrupt_inputs_n;
      irq_n <= irq_s1;
      byp_s1 <= i_latch_bypass;
      byp <= byp_s1;
    end
  end

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  logic [7:0] pending;
  logic [7:0] mask;
  logic [2:0] status;
  logic [2:0] vec_hold;
  logic vec_clr_en;
  logic req_en;
  logic group_ff;
  logic overflow;
  logic go;
  logic [7:0] clr_pend;
  logic [7:0] set_pend;

  vpic_prio_if prio ();
  vpic_prio_enc u_enc (
    .p(prio)
  );
  assign prio.pending = pending;
  assign prio.mask = mask;
  assign prio.status = status;

  assign go = !ie_n;

  // ----------------------------------------------------------------
  // pending latches
  // ----------------------------------------------------------------
  // bypass mode follows the inputs as levels; otherwise sticky
  assign set_pend = ~irq_n;

  always_comb begin
    clr_pend = 8'h00;
    if (go) begin
      case (code)
        vpic_pkg::OP_CLEAR_ALL_PEND: clr_pend = 8'hFF;
        vpic_pkg::OP_MASTER_CLEAR: clr_pend = 8'hFF;
        vpic_pkg::OP_CLEAR_PEND_MASK: clr_pend = mask;
        vpic_pkg::OP_CLEAR_PEND_BUS: clr_pend = mbus;
        vpic_pkg::OP_CLEAR_LAST_VEC: begin
          if (vec_clr_en) begin
            clr_pend = 8'h01 << vec_hold;
          end
        end
        default: clr_pend = 8'h00;
      endcase
    end
  end

  // an arriving request wins over a simultaneous clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pending <= vpic_pkg::PEND_RESET;
    end else if (byp) begin
      pending <= set_pend;
    end else begin
      pending <= (pending & ~clr_pend) | set_pend;
    end
  end

  // ----------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask <= vpic_pkg::MASK_RESET;
    end else if (go) begin
      case (code)
        vpic_pkg::OP_LOAD_MASK: mask <= mbus;
        vpic_pkg::OP_CLEAR_MASK: mask <= vpic_pkg::MASK_RESET;
        vpic_pkg::OP_SET_MASK_ALL: mask <= vpic_pkg::MASK_ALL;
        vpic_pkg::OP_BIT_MASK_CLEAR: mask <= mask & ~mbus;
        vpic_pkg::OP_BIT_MASK_SET: mask <= mask | mbus;
        vpic_pkg::OP_MASTER_CLEAR: mask <= vpic_pkg::MASK_RESET;
        default: mask <= mask;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status register, group flop, overflow
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status <= vpic_pkg::STATUS_RESET;
    end else if (go) begin
      case (code)
        vpic_pkg::OP_LOAD_STATUS: status <= sbus;
        vpic_pkg::OP_READ_VECTOR: status <= prio.vector + 3'h1;
        vpic_pkg::OP_MASTER_CLEAR: status <= vpic_pkg::STATUS_RESET;
        default: status <= status;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      group_ff <= 1'b0;
    end else if (go) begin
      case (code)
        vpic_pkg::OP_LOAD_STATUS: group_ff <= ge;
        vpic_pkg::OP_MASTER_CLEAR: group_ff <= 1'b0;
        default: group_ff <= group_ff;
      endcase
    end
  end

  // overflow reflects the latest vector read until a load status or master clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      overflow <= 1'b0;
    end else if (go) begin
      case (code)
        vpic_pkg::OP_LOAD_STATUS: overflow <= 1'b0;
        vpic_pkg::OP_READ_VECTOR: begin
          overflow <= (prio.vector == vpic_pkg::VEC_TOP);
        end
        vpic_pkg::OP_MASTER_CLEAR: overflow <= 1'b0;
        default: overflow <= overflow;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request enable
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_en <= vpic_pkg::REQ_EN_RESET;
    end else if (go) begin
      case (code)
        vpic_pkg::OP_REQ_ENABLE: req_en <= 1'b1;
        vpic_pkg::OP_REQ_DISABLE: req_en <= 1'b0;
        vpic_pkg::OP_MASTER_CLEAR: req_en <= 1'b1;
        default: req_en <= req_en;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // vector hold and clear enable
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vec_hold <= 3'h0;
    end else if (go && code == vpic_pkg::OP_READ_VECTOR) begin
      vec_hold <= prio.vector;
    end
  end

  // a clear of the last vector is honoured once per vector read
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vec_clr_en <= 1'b0;
    end else if (go && code == vpic_pkg::OP_READ_VECTOR) begin
      vec_clr_en <= 1'b1;
    end else if (go && code == vpic_pkg::OP_CLEAR_LAST_VEC) begin
      vec_clr_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read-back outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mask_bus <= 8'h00;
      o_mask_bus_oe <= 1'b0;
    end else begin
      o_mask_bus_oe <= go && code == vpic_pkg::OP_READ_MASK;
      o_mask_bus <= mask;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status_bus <= 3'h0;
      o_status_bus_oe <= 1'b0;
    end else begin
      o_status_bus_oe <= go && code == vpic_pkg::OP_READ_STATUS;
      o_status_bus <= status;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vector_out <= 3'h0;
      o_vector_oe <= 1'b0;
    end else begin
      o_vector_oe <= go && code == vpic_pkg::OP_READ_VECTOR;
      if (go && code == vpic_pkg::OP_READ_VECTOR) begin
        o_vector_out <= prio.vector;
      end
    end
  end

  // ----------------------------------------------------------------
  // request and flag outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_interrupt_request_out <= 1'b0;
    end else begin
      o_interrupt_request_out <= prio.at_level && req_en;
    end
  end

  assign o_status_overflow = overflow;
  assign o_lowest_group_enabled = group_ff;
endmodule : vpic_ctrl

// ===== bench/vpic_host.sv
// vpic_host: host model strobing instruction codes into the controller
// assumes: bench calls issue() from its main sequence only
`timescale 1ns/100ps
module vpic_host (
  input wire logic i_clock,
  output logic o_en_n,
  output logic [3:0] o_code,
  output logic [7:0] o_mask,
  output logic [2:0] o_status,
  output logic o_group
);
  initial begin
    o_en_n = 1'b1;
    o_code = 4'hF;
    o_mask = 8'h00;
    o_status = 3'h0;
    o_group = 1'b0;
  end
  // one strobe cycle, buses held until next call
  task automatic issue(input logic [3:0] c, input logic [7:0] m,
    input logic [2:0] s, input logic g, input logic e);
    @(posedge i_clock);
    o_en_n <= e;
    o_code <= c;
    o_mask <= m;
    o_status <= s;
    o_group <= g;
    @(posedge i_clock);
    o_en_n <= 1'b1;
  endtask : issue
endmodule : vpic_host

// ===== bench/vpic_ctrl_checker.sv
// vpic_checker: timing of the controller outputs against the strobe
// assumes: bound to vpic_ctrl, codes take effect three edges later
`timescale 1ns/100ps
module vpic_checker (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_instruction_enable_n,
  input wire logic [3:0] i_instruction_code,
  input wire logic [7:0] o_mask_bus,
  input wire logic o_mask_bus_oe,
  input wire logic [2:0] o_status_bus,
  input wire logic o_status_bus_oe,
  input wire logic o_lowest_group_enabled,
  input wire logic [2:0] o_vector_out,
  input wire logic o_vector_oe,
  input wire logic o_interrupt_request_out,
  input wire logic o_status_overflow
);
  logic go;
  logic read_mask;
  logic rdv;
  assign go = !i_instruction_enable_n;
  assign read_mask = go && i_instruction_code == vpic_pkg::OP_READ_MASK;
  assign rdv = go && i_instruction_code == vpic_pkg::OP_READ_VECTOR;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  read_mask_a: assert property (read_mask |-> ##3 o_mask_bus_oe)
    else $error("mask read not driven");
  mask_oe_cause_a: assert property (o_mask_bus_oe |-> $past(read_mask, 3))
    else $error("mask bus driven without read");
  read_status_a: assert property (go && i_instruction_code ==
    vpic_pkg::OP_READ_STATUS |-> ##3 o_status_bus_oe)
    else $error("status read not driven");
  read_vector_a: assert property (rdv |-> ##3 o_vector_oe)
    else $error("vector read not driven");
  vec_oe_cause_a: assert property (o_vector_oe |-> $past(rdv, 3))
    else $error("vector driven without read");
  overflow_set_a: assert property (o_vector_oe &&
    o_vector_out == 3'h7 |-> ##[0:1] o_status_overflow)
    else $error("overflow not set");
  req_disable_a: assert property (go && i_instruction_code ==
    vpic_pkg::OP_REQ_DISABLE |-> ##5 !o_interrupt_request_out)
    else $error("request not disabled");
  master_clear_a: assert property (go && i_instruction_code ==
    vpic_pkg::OP_MASTER_CLEAR |-> ##4 o_mask_bus == 8'h00 &&
    o_status_bus == 3'h0 && !o_lowest_group_enabled)
    else $error("master clear incomplete");
  set_mask_a: assert property (go && i_instruction_code ==
    vpic_pkg::OP_SET_MASK_ALL |-> ##4 o_mask_bus == 8'hFF)
    else $error("mask not set");
  cover property (rdv ##3 o_vector_oe);
  cover property (o_status_overflow);
  cover property (o_interrupt_request_out);
endmodule : vpic_checker
bind vpic_ctrl vpic_checker chk_u (.i_clock, .i_reset_n,
  .i_instruction_enable_n, .i_instruction_code, .o_mask_bus,
  .o_mask_bus_oe, .o_status_bus, .o_status_bus_oe,
  .o_lowest_group_enabled, .o_vector_out, .o_vector_oe,
  .o_interrupt_request_out, .o_status_overflow);

// ===== bench/vectored_priority_irq_ctrl_tb.sv
// vectored_priority_irq_ctrl_tb: instruction set walk of vpic_ctrl
// assumes: vpic_host drives the host side, bench drives interrupts
`timescale 1ns/100ps
module vectored_priority_irq_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] irq_n = 8'hFF;
  logic byp = 1'b0;
  logic en_n;
  logic grp;
  logic [3:0] code;
  logic [7:0] mbi;
  logic [7:0] mbo;
  logic [2:0] sbi;
  logic [2:0] sbo;
  logic [2:0] vec;
  logic moe, soe, voe, lowest_group_enabled_ff, req, ovf;
  logic [7:0] s_mb;
  logic [2:0] s_sb, s_vec;
  logic s_moe, s_soe, s_voe;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  vpic_host host_u (.i_clock(clk), .o_en_n(en_n), .o_code(code),
    .o_mask(mbi), .o_status(sbi), .o_group(grp));
  vpic_ctrl dut_u (.i_clock(clk), .i_reset_n(rst_n),
    .i_instruction_enable_n(en_n), .i_instruction_code(code),
    .i_interrupt_inputs_n(irq_n), .i_latch_bypass(byp),
    .i_mask_bus(mbi), .o_mask_bus(mbo), .o_mask_bus_oe(moe),
    .i_status_bus(sbi), .o_status_bus(sbo), .o_status_bus_oe(soe),
    .i_group_enable_in(grp), .o_lowest_group_enabled(lowest_group_enabled_ff),
    .o_vector_out(vec), .o_vector_oe(voe),
    .o_interrupt_request_out(req), .o_status_overflow(ovf));
  task automatic final_report;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // snapshot the one-cycle outputs, then let state settle
  task automatic op(input logic [3:0] c, input logic [7:0] m = 8'h00,
    input logic [2:0] s = 3'h0, input logic g = 1'b0,
    input logic e = 1'b0);
    host_u.issue(c, m, s, g, e);
    repeat (2) @(posedge clk);
    #1;
    s_mb = mbo;
    s_moe = moe;
    s_sb = sbo;
    s_soe = soe;
    s_vec = vec;
    s_voe = voe;
    repeat (3) @(posedge clk);
    #1;
  endtask : op
  task automatic raise(input logic [7:0] b);
    @(posedge clk);
    irq_n <= ~b;
    repeat (3) @(posedge clk);
    irq_n <= 8'hFF;
    repeat (4) @(posedge clk);
    #1;
  endtask : raise
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("mask", mbo, 8'h00);
    op(vpic_pkg::OP_LOAD_MASK, 8'hA5);
    op(vpic_pkg::OP_READ_MASK);
    chk("moe", s_moe, 1'b1);
    chk("mbus", s_mb, 8'hA5);
    op(vpic_pkg::OP_BIT_MASK_CLEAR, 8'h0F);
    chk("mask", mbo, 8'hA0);
    op(vpic_pkg::OP_BIT_MASK_SET, 8'h03);
    chk("mask", mbo, 8'hA3);
    op(vpic_pkg::OP_CLEAR_MASK, 8'h00, 3'h0, 1'b0, 1'b1);
    chk("mask", mbo, 8'hA3);
    op(vpic_pkg::OP_CLEAR_MASK);
    chk("mask", mbo, 8'h00);
    op(vpic_pkg::OP_SET_MASK_ALL);
    chk("mask", mbo, 8'hFF);
    op(vpic_pkg::OP_LOAD_STATUS, 8'h00, 3'h2, 1'b1);
    chk("lge", lowest_group_enabled_ff, 1'b1);
    op(vpic_pkg::OP_READ_STATUS);
    chk("soe", s_soe, 1'b1);
    chk("sbus", s_sb, 3'h2);
    op(vpic_pkg::OP_CLEAR_MASK);
    op(vpic_pkg::OP_LOAD_STATUS);
    raise(8'h24);
    chk("req", req, 1'b1);
    op(vpic_pkg::OP_READ_VECTOR);
    chk("voe", s_voe, 1'b1);
    chk("vec", s_vec, 3'h5);
    chk("status", sbo, 3'h6);
    op(vpic_pkg::OP_CLEAR_LAST_VEC);
    op(vpic_pkg::OP_READ_VECTOR);
    chk("vec", s_vec, 3'h2);
    op(vpic_pkg::OP_LOAD_STATUS);
    op(vpic_pkg::OP_REQ_DISABLE);
    chk("req", req, 1'b0);
    op(vpic_pkg::OP_REQ_ENABLE);
    chk("req", req, 1'b1);
    op(vpic_pkg::OP_CLEAR_PEND_BUS, 8'h04);
    chk("req", req, 1'b0);
    raise(8'h80);
    op(vpic_pkg::OP_READ_VECTOR);
    chk("vec", s_vec, 3'h7);
    chk("ovf", ovf, 1'b1);
    op(vpic_pkg::OP_CLEAR_ALL_PEND);
    chk("req", req, 1'b0);
    raise(8'h02);
    op(vpic_pkg::OP_LOAD_MASK, 8'h02);
    op(vpic_pkg::OP_CLEAR_PEND_MASK);
    op(vpic_pkg::OP_CLEAR_MASK);
    chk("req", req, 1'b0);
    op(vpic_pkg::OP_LOAD_STATUS, 8'h00, 3'h5, 1'b1);
    op(vpic_pkg::OP_SET_MASK_ALL);
    op(vpic_pkg::OP_REQ_DISABLE);
    op(vpic_pkg::OP_MASTER_CLEAR);
    chk("mask", mbo, 8'h00);
    chk("status", sbo, 3'h0);
    chk("lge", lowest_group_enabled_ff, 1'b0);
    raise(8'h01);
    chk("req", req, 1'b1);
    @(posedge clk);
    byp <= 1'b1;
    raise(8'h08);
    chk("req", req, 1'b0);
    final_report();
  end
endmodule : vectored_priority_irq_ctrl_tb
